/* File: pdmc_power_ctrl.v */
// power-down mode controller: sleep, subactive, direct transition and reset pin
`include "pdmc_consts.vh"
`default_nettype none


module pdmc_power_ctrl #(
    parameter [23:0] WAIT_BASE = `PDMC_WAIT_BASE_STATES
) (
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire [15:0] reg_addr_i,
    input  wire [7:0]  reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [7:0]  reg_rdata_o,
    input  wire        sleep_exec_i,
    input  wire        cpu_imask_i,
    input  wire        periph_irq_i,
    input  wire        ext_irq_i,
    input  wire        sub_clk_i,
    input  wire        reset_pin_n_i,
    output reg  [2:0]  power_mode_o,
    output wire        cpu_halt_o,
    output wire        cpu_sub_clock_o,
    output wire [2:0]  osc_clk_sel_o,
    output wire        osc_full_rate_o,
    output wire [1:0]  sub_clk_sel_o,
    output wire        sub_div8_o,
    output reg         irq_accept_o,
    output wire        irq_pending_o,
    output wire        chip_reset_o,
    output reg         reset_exc_o,
    output wire        wait_busy_o
);

    // ********************************************************************
    // mode states
    // ********************************************************************
    localparam [2:0] ST_ACTIVE    = 3'h0;
    localparam [2:0] ST_SLEEP     = 3'h1;
    localparam [2:0] ST_SUBACTIVE = 3'h2;
    localparam [2:0] ST_WAIT      = 3'h3;
    localparam [2:0] ST_RESET     = 3'h4;

    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [7:0]  timer_a_mode;
    reg  [7:0]  timer_a_count;
    reg  [7:0]  system_control_one;
    reg  [7:0]  system_control_two;
    reg  [7:0]  interrupt_enable_one;
    reg  [7:0]  interrupt_request_one;
    reg  [7:0]  next_request;
    reg  [7:0]  next_rdata;
    reg         sub_clk_prev;
    reg         reset_pin_prev;

    wire        reset_pin_sync;
    wire        ext_irq_sync;
    wire        sub_clk_sync;
    wire        sub_edge;
    wire        regs_rst_n;
    wire        soft_standby_select;
    wire        sleep_kind_select;
    wire        low_speed_flag;
    wire        direct_transfer_flag;
    wire [2:0]  standby_wait_sel;
    wire        enter_sleep;
    wire        enter_direct;
    wire        wake_req;
    wire        timebase_on;
    wire        prescale_zero;
    wire        timebase_tick;
    wire        timer_overflow;
    wire        wait_zero;
    wire        wait_load;
    wire [23:0] wait_len;
    wire        direct_done;
    wire        wr_mode;
    wire        wr_irq;

    // ********************************************************************
    // pin synchronisers
    // ********************************************************************
    // reset pin idles high so its chain starts high
    pdmc_sync3 #(
        .INIT (1'b1)
    ) u_sync_reset (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (reset_pin_n_i),
        .sync_o  (reset_pin_sync)
    );

    pdmc_sync3 #(
        .INIT (1'b0)
    ) u_sync_ext (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (ext_irq_i),
        .sync_o  (ext_irq_sync)
    );

    pdmc_sync3 #(
        .INIT (1'b0)
    ) u_sync_sub (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i (sub_clk_i),
        .sync_o  (sub_clk_sync)
    );

    // edge history of the settled pin levels
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            sub_clk_prev   <= 1'b0;
            reset_pin_prev <= 1'b1;
        end else begin
            sub_clk_prev   <= sub_clk_sync;
            reset_pin_prev <= reset_pin_sync;
        end
    end

    assign sub_edge   = sub_clk_sync & ~sub_clk_prev;
    // registers also clear while the reset pin is low
    assign regs_rst_n = rst_n_i & reset_pin_sync;

    // ********************************************************************
    // control fields
    // ********************************************************************
    assign soft_standby_select  = system_control_one[`PDMC_SOFT_STANDBY_SELECT];
    assign standby_wait_sel     = system_control_one[`PDMC_STANDBY_WAIT_SEL_HI:
                                                     `PDMC_STANDBY_WAIT_SEL_LO];
    assign sleep_kind_select    = system_control_two[`PDMC_SLEEP_KIND_SELECT];
    assign low_speed_flag       = system_control_two[`PDMC_LOW_SPEED_FLAG];
    assign direct_transfer_flag = system_control_two[`PDMC_DIRECT_TRANSFER_FLAG];

    // sleep from active: standby and sleep kind clear, no direct flag
    assign enter_sleep  = sleep_exec_i & (state == ST_ACTIVE)
                        & ~soft_standby_select & ~sleep_kind_select
                        & ~direct_transfer_flag;
    // direct hop: standby and sleep kind do not matter here
    assign enter_direct = sleep_exec_i & (state == ST_SUBACTIVE)
                        & ~low_speed_flag & direct_transfer_flag;

    // ********************************************************************
    // interrupt requests
    // ********************************************************************
    // a masked cpu or a disabled source leaves sleep in place
    assign irq_pending_o = periph_irq_i
                         | (|(interrupt_request_one & interrupt_enable_one
                              & `PDMC_IRQ_FLAG_MASK));
    assign wake_req      = ~cpu_imask_i & irq_pending_o;

    assign wr_irq = reg_wr_i & (reg_addr_i == `PDMC_ADDR_INTERRUPT_REQUEST_ONE);

    // request flags: hardware set beats a software write of zero
    always @* begin
        next_request = interrupt_request_one;
        if (wr_irq) begin
            next_request = interrupt_request_one & reg_wdata_i;
        end
        if (direct_done) begin
            next_request[`PDMC_DIRECT_IRQ_BIT] = 1'b1;
        end
        if (timer_overflow) begin
            next_request[`PDMC_TIMEBASE_IRQ_BIT] = 1'b1;
        end
        if (ext_irq_sync) begin
            next_request[`PDMC_EXT_IRQ_BIT] = 1'b1;
        end
        next_request = next_request & `PDMC_IRQ_FLAG_MASK;
    end

    // ********************************************************************
    // timer a time base
    // ********************************************************************
    // sub-clock edges are prescaled into the counter tick
    assign timebase_on   = (timer_a_mode == `PDMC_TIMER_A_TIMEBASE);
    assign wr_mode       = reg_wr_i & (reg_addr_i == `PDMC_ADDR_TIMER_A_MODE);
    assign timebase_tick = timebase_on & sub_edge & prescale_zero;
    assign timer_overflow = timebase_tick & (timer_a_count == 8'hFF);

    pdmc_down_count #(
        .W (8)
    ) u_prescale (
        .clock_i    (clock_i),
        .rst_n_i    (regs_rst_n),
        .load_i     (wr_mode | timebase_tick),
        .load_val_i (`PDMC_TIMEBASE_PRESCALE - 8'h01),
        .dec_i      (timebase_on & sub_edge),
        .count_o    (),
        .zero_o     (prescale_zero)
    );

    // eight-bit up-counter, overflow raises the timer request
    always @(posedge clock_i) begin
        if (!regs_rst_n) begin
            timer_a_count <= 8'h00;
        end else if (wr_mode) begin
            timer_a_count <= 8'h00;
        end else if (timebase_tick) begin
            timer_a_count <= timer_a_count + 8'h01;
        end
    end

    // ********************************************************************
    // standby wait timer
    // ********************************************************************
    // field value n gives base times two to the n states
    assign wait_len  = WAIT_BASE << standby_wait_sel;
    assign wait_load = enter_direct;

    pdmc_down_count #(
        .W (24)
    ) u_wait (
        .clock_i    (clock_i),
        .rst_n_i    (regs_rst_n),
        .load_i     (wait_load),
        .load_val_i (wait_len - 24'h000001),
        .dec_i      (state == ST_WAIT),
        .count_o    (),
        .zero_o     (wait_zero)
    );

    assign direct_done = (state == ST_WAIT) & wait_zero;
    assign wait_busy_o = (state == ST_WAIT);

    // ********************************************************************
    // mode sequencer
    // ********************************************************************
    // next mode from present mode, sleep command and wake requests
    always @* begin
        next_state = state;
        case (state)
            ST_ACTIVE: begin
                if (enter_sleep) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (wake_req) begin
                    // resume speed follows the low speed flag
                    next_state = low_speed_flag ? ST_SUBACTIVE : ST_ACTIVE;
                end
            end
            ST_SUBACTIVE: begin
                if (enter_direct) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (wait_zero) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_RESET: begin
                next_state = ST_ACTIVE;
            end
            default: begin
                next_state = ST_ACTIVE;
            end
        endcase
    end

    // pin low forces reset and cancels any sleep
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            state <= ST_RESET;
        end else if (!reset_pin_sync) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // wake handshake and reset exception strobes
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_accept_o <= 1'b0;
            reset_exc_o  <= 1'b0;
            power_mode_o <= ST_RESET;
        end else begin
            irq_accept_o <= (state == ST_SLEEP) & wake_req & reset_pin_sync;
            reset_exc_o  <= reset_pin_sync & ~reset_pin_prev;
            power_mode_o <= reset_pin_sync ? next_state : ST_RESET;
        end
    end

    // ********************************************************************
    // clock and halt outputs
    // ********************************************************************
    // peripherals keep their clock choice while the cpu is halted in sleep or wait
    assign cpu_halt_o      = (state == ST_SLEEP) | (state == ST_WAIT)
                           | (state == ST_RESET);
    assign chip_reset_o    = (state == ST_RESET);
    assign cpu_sub_clock_o = (state == ST_SUBACTIVE);
    assign osc_clk_sel_o   = system_control_two[`PDMC_ACTIVE_CLK_SEL_HI:
                                                `PDMC_ACTIVE_CLK_SEL_LO];
    assign osc_full_rate_o = (osc_clk_sel_o == `PDMC_OSC_UNDIVIDED);
    assign sub_clk_sel_o   = system_control_two[`PDMC_SUB_CLK_SEL_HI:
                                                `PDMC_SUB_CLK_SEL_LO];
    assign sub_div8_o      = (sub_clk_sel_o == `PDMC_SUB_DIV8);

    // ********************************************************************
    // register writes
    // ********************************************************************
    // control registers written by software
    always @(posedge clock_i) begin
        if (!regs_rst_n) begin
            timer_a_mode          <= `PDMC_RST_TIMER_A_MODE;
            system_control_one    <= `PDMC_RST_SYSTEM_CONTROL_ONE;
            system_control_two    <= `PDMC_RST_SYSTEM_CONTROL_TWO;
            interrupt_enable_one  <= `PDMC_RST_INTERRUPT_ENABLE_ONE;
            interrupt_request_one <= `PDMC_RST_INTERRUPT_REQUEST_ONE;
        end else begin
            interrupt_request_one <= next_request;
            if (wr_mode) begin
                timer_a_mode <= reg_wdata_i;
            end
            if (reg_wr_i && (reg_addr_i == `PDMC_ADDR_SYSTEM_CONTROL_ONE)) begin
                system_control_one <= reg_wdata_i;
            end
            if (reg_wr_i && (reg_addr_i == `PDMC_ADDR_SYSTEM_CONTROL_TWO)) begin
                system_control_two <= reg_wdata_i;
            end
            if (reg_wr_i && (reg_addr_i == `PDMC_ADDR_INTERRUPT_ENABLE_ONE)) begin
                interrupt_enable_one <= reg_wdata_i;
            end
        end
    end

    // ********************************************************************
    // register reads
    // ********************************************************************
    // read mux, unmapped addresses answer zero
    always @* begin
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `PDMC_ADDR_TIMER_A_MODE:          next_rdata = timer_a_mode;
                `PDMC_ADDR_TIMER_A_COUNT:         next_rdata = timer_a_count;
                `PDMC_ADDR_SYSTEM_CONTROL_ONE:    next_rdata = system_control_one;
                `PDMC_ADDR_SYSTEM_CONTROL_TWO:    next_rdata = system_control_two;
                `PDMC_ADDR_INTERRUPT_ENABLE_ONE:  next_rdata = interrupt_enable_one;
                `PDMC_ADDR_INTERRUPT_REQUEST_ONE: next_rdata = interrupt_request_one;
                default:                          next_rdata = 8'h00;
            endcase
        end
    end

    // read data stands one cycle after the strobe only
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule // pdmc_power_ctrl

`default_nettype wire

/* File: pdmc_consts.vh */
// register map, field positions, reset values and timing counts of the power-down controller
`ifndef PDMC_CONSTS_VH
`define PDMC_CONSTS_VH

// ********************************************************************
// register byte addresses
// ********************************************************************
`define PDMC_ADDR_TIMER_A_MODE      16'hFFA6
`define PDMC_ADDR_TIMER_A_COUNT     16'hFFA7
`define PDMC_ADDR_SYSTEM_CONTROL_ONE 16'hFFF0
`define PDMC_ADDR_SYSTEM_CONTROL_TWO 16'hFFF1
`define PDMC_ADDR_INTERRUPT_ENABLE_ONE 16'hFFF4
`define PDMC_ADDR_INTERRUPT_REQUEST_ONE 16'hFFF6

// ********************************************************************
// field positions
// ********************************************************************
`define PDMC_SOFT_STANDBY_SELECT   7
`define PDMC_STANDBY_WAIT_SEL_HI   6
`define PDMC_STANDBY_WAIT_SEL_LO   4
`define PDMC_SLEEP_KIND_SELECT     7
`define PDMC_LOW_SPEED_FLAG        6
`define PDMC_DIRECT_TRANSFER_FLAG  5
`define PDMC_ACTIVE_CLK_SEL_HI     4
`define PDMC_ACTIVE_CLK_SEL_LO     2
`define PDMC_SUB_CLK_SEL_HI        1
`define PDMC_SUB_CLK_SEL_LO        0
`define PDMC_DIRECT_IRQ_BIT        7
`define PDMC_TIMEBASE_IRQ_BIT      6
`define PDMC_EXT_IRQ_BIT           0

// ********************************************************************
// reset values and encodings
// ********************************************************************
`define PDMC_RST_TIMER_A_MODE      8'h00
`define PDMC_RST_SYSTEM_CONTROL_ONE 8'h00
`define PDMC_RST_SYSTEM_CONTROL_TWO 8'h00
`define PDMC_RST_INTERRUPT_ENABLE_ONE 8'h00
`define PDMC_RST_INTERRUPT_REQUEST_ONE 8'h00
`define PDMC_TIMER_A_TIMEBASE      8'h19
`define PDMC_OSC_UNDIVIDED         3'h3
`define PDMC_SUB_DIV8              2'h0
`define PDMC_IRQ_FLAG_MASK         8'hC1

// ********************************************************************
// timing counts
// ********************************************************************
`define PDMC_WAIT_BASE_STATES      24'h002000
`define PDMC_TIMEBASE_PRESCALE     8'h40

`endif

/* File: pdmc_sync3.v */
// three-stage synchroniser that passes a change once stages two and three agree
`default_nettype none

module pdmc_sync3 #(
    parameter [0:0] INIT = 1'b0
) (
    input  wire clock_i,
    input  wire rst_n_i,
    input  wire async_i,
    output reg  sync_o
);

    reg stage_one;
    reg stage_two;
    reg stage_three;

    // ********************************************************************
    // synchroniser chain
    // ********************************************************************
    // stage one is read only by stage two
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            stage_one   <= INIT;
            stage_two   <= INIT;
            stage_three <= INIT;
            sync_o      <= INIT;
        end else begin
            stage_one   <= async_i;
            stage_two   <= stage_one;
            stage_three <= stage_two;
            if (stage_two == stage_three) begin
                sync_o <= stage_three; // change counts once both agree
            end
        end
    end

endmodule // pdmc_sync3

`default_nettype wire

/* File: pdmc_down_count.v */
// loadable down-counter with a zero flag
`default_nettype none

module pdmc_down_count #(
    parameter W = 24
) (
    input  wire         clock_i,
    input  wire         rst_n_i,
    input  wire         load_i,
    input  wire [W-1:0] load_val_i,
    input  wire         dec_i,
    output reg  [W-1:0] count_o,
    output wire         zero_o
);

    // ********************************************************************
    // counter
    // ********************************************************************
    // load has priority over decrement; count stops at zero
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            count_o <= {W{1'b0}};
        end else if (load_i) begin
            count_o <= load_val_i;
        end else if (dec_i && (count_o != {W{1'b0}})) begin
            count_o <= count_o - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign zero_o = (count_o == {W{1'b0}});

endmodule // pdmc_down_count

`default_nettype wire

/* File: pdmc_checker.sv */
// assertion checker bound to the power-down mode controller ports
`default_nettype none
module pdmc_checker #(
    parameter int WAIT_BASE = 4
) (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [7:0]  reg_wdata_i,
    input wire logic        reg_wr_i,
    input wire logic        sleep_exec_i,
    input wire logic        cpu_imask_i,
    input wire logic        reset_pin_n_i,
    input wire logic        cpu_halt_o,
    input wire logic        cpu_sub_clock_o,
    input wire logic [2:0]  osc_clk_sel_o,
    input wire logic        osc_full_rate_o,
    input wire logic [1:0]  sub_clk_sel_o,
    input wire logic        sub_div8_o,
    input wire logic        irq_accept_o,
    input wire logic        irq_pending_o,
    input wire logic        chip_reset_o,
    input wire logic        reset_exc_o,
    input wire logic        wait_busy_o
);
    logic [7:0] sc1;
    logic [7:0] sc2;
    int         wlen;
    wire        act  = !cpu_halt_o && !cpu_sub_clock_o && !chip_reset_o;
    wire        slp  = cpu_halt_o && !wait_busy_o && !chip_reset_o;
    wire        wake = slp && !cpu_imask_i && irq_pending_o;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // shadow of the control registers and length of the running wait
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || chip_reset_o) begin
            sc1 <= 8'h00;
            sc2 <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == 16'hFFF0) begin
            sc1 <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == 16'hFFF1) begin
            sc2 <= reg_wdata_i;
        end
        wlen <= wait_busy_o ? wlen + 1 : 0;
    end
    AST_SLEEP_IN:
    assert property (act && sleep_exec_i && !sc1[7] && sc2[7:5] == 3'h2 |=> cpu_halt_o)
        else $error("sleep not entered");
    AST_SLEEP_REFUSED:
    assert property (act && sleep_exec_i && (sc1[7] || sc2[7] || sc2[5]) |=> !cpu_halt_o)
        else $error("sleep entered with other selection");
    AST_DIRECT_START:
    assert property (cpu_sub_clock_o && !cpu_halt_o && sleep_exec_i && sc2[6:5] == 2'h1
        |=> wait_busy_o) else $error("direct wait not started");
    AST_WAIT_LEN:
    assert property ($fell(wait_busy_o) && !chip_reset_o
        |-> wlen == (WAIT_BASE << sc1[6:4]) && act) else $error("wait length wrong");
    AST_STAY_ASLEEP:
    assert property (slp && (cpu_imask_i || !irq_pending_o) |=> cpu_halt_o)
        else $error("left sleep without unmasked request");
    AST_WAKE:
    assert property (wake |=> !cpu_halt_o && irq_accept_o) else $error("wake missing");
    AST_WAKE_SUB:
    assert property (wake && sc2[6] |=> cpu_sub_clock_o) else $error("not in subactive");
    AST_OSC_SEL:
    assert property (reg_wr_i && reg_addr_i == 16'hFFF1 |=> osc_clk_sel_o == sc2[4:2]
        && osc_full_rate_o == (sc2[4:2] == 3'h3)) else $error("active clock select wrong");
    AST_SUB_SEL:
    assert property (reg_wr_i && reg_addr_i == 16'hFFF1 |=> sub_clk_sel_o == sc2[1:0]
        && sub_div8_o == (sc2[1:0] == 2'h0)) else $error("sub clock select wrong");
    AST_PIN_RESET:
    assert property (!reset_pin_n_i [*7] |-> chip_reset_o && cpu_halt_o)
        else $error("reset pin ignored");
    AST_RESET_EXC:
    assert property (reset_exc_o |-> reset_pin_n_i ##1 !reset_exc_o)
        else $error("reset handling pulse wrong");
endmodule // pdmc_checker

bind pdmc_power_ctrl pdmc_checker #(.WAIT_BASE(WAIT_BASE)) u_chk (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .sleep_exec_i(sleep_exec_i), .cpu_imask_i(cpu_imask_i),
    .reset_pin_n_i(reset_pin_n_i), .cpu_halt_o(cpu_halt_o),
    .cpu_sub_clock_o(cpu_sub_clock_o), .osc_clk_sel_o(osc_clk_sel_o),
    .osc_full_rate_o(osc_full_rate_o), .sub_clk_sel_o(sub_clk_sel_o),
    .sub_div8_o(sub_div8_o), .irq_accept_o(irq_accept_o), .irq_pending_o(irq_pending_o),
    .chip_reset_o(chip_reset_o), .reset_exc_o(reset_exc_o), .wait_busy_o(wait_busy_o));
`default_nettype wire

/* File: pdmc_cpu_model.sv */
// cpu core model: issues the sleep instruction and holds the interrupt mask
`default_nettype none
module pdmc_cpu_model (
    input  wire logic clock_i,
    input  wire logic cpu_halt_i,
    input  wire logic irq_accept_i,
    input  wire logic mask_req_i,
    output var  logic sleep_exec_o,
    output var  logic cpu_imask_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int n_taken = 0;
    initial sleep_exec_o = 1'b0;
    initial cpu_imask_o = 1'b0;
    // mask follows the program at the edge; wake-ups taken are counted
    always @(posedge clock_i) begin
        cpu_imask_o <= mask_req_i;
        if (irq_accept_i === 1'b1)
            n_taken <= n_taken + 1;
    end
    // a halted core fetches nothing, so the instruction waits until it runs
    task automatic exec_sleep();
        @(posedge clock_i);
        while (cpu_halt_i !== 1'b0)
            @(posedge clock_i);
        sleep_exec_o <= 1'b1;
        @(posedge clock_i);
        sleep_exec_o <= 1'b0;
    endtask
endmodule // pdmc_cpu_model
`default_nettype wire

/* File: power_down_mode_control_tb.sv */
// self-checking bench for the power-down mode controller
`default_nettype none
module power_down_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wd = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        mask_req = 1'b0;
    logic        ext_irq = 1'b0;
    logic        sub_clk = 1'b0;
    logic        pin_n = 1'b1;
    logic [7:0]  rdata;
    logic [2:0]  osc_sel;
    logic [1:0]  sub_sel;
    logic        sexec, imask, halt, subclk, osc_full, div8, acc, chrst, rexc, wbusy;
    int          errors = 0;
    int          n_compared = 0;
    int          n;
    logic [32:0] rows [8] = '{{1'b0, 16'hFFF0, 16'h0000}, {1'b0, 16'hFFF1, 16'h0000},
        {1'b0, 16'hFFF6, 16'h0000}, {1'b1, 16'hFFA7, 16'h5500}, {1'b1, 16'hFFF4, 16'hC1C1},
        {1'b1, 16'hFFF6, 16'hFF00}, {1'b1, 16'h1234, 16'hAA00}, {1'b1, 16'hFFF1, 16'h0C0C}};
    logic [15:0] bad [3] = '{16'h804C, 16'h00CC, 16'h006C};
    always #25 clk = ~clk;
    always #100 sub_clk = ~sub_clk;
    pdmc_power_ctrl #(.WAIT_BASE(24'h000004)) DUT (.clock_i(clk), .rst_n_i(rst_n),
        .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .sleep_exec_i(sexec), .cpu_imask_i(imask),
        .periph_irq_i(1'b0), .ext_irq_i(ext_irq), .sub_clk_i(sub_clk),
        .reset_pin_n_i(pin_n), .power_mode_o(), .cpu_halt_o(halt),
        .cpu_sub_clock_o(subclk), .osc_clk_sel_o(osc_sel), .osc_full_rate_o(osc_full),
        .sub_clk_sel_o(sub_sel), .sub_div8_o(div8), .irq_accept_o(acc),
        .irq_pending_o(), .chip_reset_o(chrst), .reset_exc_o(rexc), .wait_busy_o(wbusy));
    pdmc_cpu_model u_cpu (.clock_i(clk), .cpu_halt_i(halt), .irq_accept_i(acc),
        .mask_req_i(mask_req), .sleep_exec_o(sexec), .cpu_imask_o(imask));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic bus_rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk("read data", {24'h0, e}, {24'h0, rdata});
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        $display("CHECK FAILED watchdog expected finish seen hang");
        test_done();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (rows[i][32])
                bus_wr(rows[i][31:16], rows[i][15:8]);
            bus_rd(rows[i][31:16], rows[i][7:0]);
        end
        chk("full rate", 1, osc_full);
        chk("div eight", 1, div8);
        $display("register rows done");
        for (int j = 0; j < 3; j++) begin
            bus_wr(16'hFFF0, bad[j][15:8]);
            bus_wr(16'hFFF1, bad[j][7:0]);
            u_cpu.exec_sleep();
            repeat (2) @(posedge clk);
            chk("halt refused", 0, halt);
        end
        $display("refused sleep done");
        bus_wr(16'hFFF0, 8'h00);
        bus_wr(16'hFFF1, 8'h4C);
        bus_wr(16'hFFF4, 8'h01);
        mask_req <= 1'b1;
        u_cpu.exec_sleep();
        ext_irq <= 1'b1;
        repeat (20) @(posedge clk);
        chk("masked sleep", 1, halt);
        mask_req <= 1'b0;
        for (n = 0; n < 10 && acc !== 1'b1; n++) @(negedge clk);
        chk("wake pulse", 1, acc);
        chk("subactive", 1, subclk);
        bus_rd(16'hFFF6, 8'h01);
        chk("taken", 1, u_cpu.n_taken);
        ext_irq <= 1'b0;
        repeat (6) @(posedge clk);
        bus_wr(16'hFFF6, 8'h00);
        bus_rd(16'hFFF6, 8'h00);
        $display("masked wake done");
        bus_wr(16'hFFF0, 8'h40);
        bus_wr(16'hFFF4, 8'h80);
        bus_wr(16'hFFF1, 8'h2C);
        u_cpu.exec_sleep();
        for (n = 0; n < 10 && wbusy !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 300 && wbusy === 1'b1; n++) @(posedge clk);
        chk("wait cycles", 4 << 4, n);
        chk("active after wait", 0, {halt, subclk});
        bus_rd(16'hFFF6, 8'h80);
        bus_wr(16'hFFF6, 8'h00);
        bus_rd(16'hFFF6, 8'h00);
        $display("direct transition done");
        bus_wr(16'hFFF4, 8'h40);
        bus_wr(16'hFFF1, 8'h4C);
        bus_wr(16'hFFA6, 8'h19);
        u_cpu.exec_sleep();
        for (n = 0; n < 70000 && acc !== 1'b1; n++) @(posedge clk);
        chk("timebase period", 1, n > 65000 && n < 66100);
        chk("timer subactive", 1, subclk);
        bus_rd(16'hFFF6, 8'h40);
        bus_wr(16'hFFA6, 8'h00);
        $display("timer wake done");
        pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk("pin reset", 1, chrst & halt);
        pin_n <= 1'b1;
        for (n = 0; n < 10 && rexc !== 1'b1; n++) @(posedge clk);
        chk("reset handling", 1, rexc);
        repeat (3) @(posedge clk);
        chk("out of reset", 0, chrst);
        bus_rd(16'hFFF1, 8'h00);
        $display("reset pin done");
        test_done();
    end
endmodule // power_down_mode_control_tb
`default_nettype wire
